// file: crrac_pkg.sv
// crrac_pkg: register map, field layout, reset values and timing counts
// for the reference, soft reset and audio control block.
// assumes a 50 MHz mclk and 32-bit AXI4-Lite, one register per word.
package crrac_pkg;

  // register indices; byte address is four times the index, plus PAGE2_BASE for the audio word
  localparam logic [3:0] RSVD_A_IDX    = 4'h2;
  localparam logic [3:0] REF_CTL_IDX   = 4'h3;
  localparam logic [3:0] SOFT_RST_IDX  = 4'h4;
  localparam logic [3:0] RSVD_B_IDX    = 4'h5;
  localparam logic [3:0] STATUS_IDX    = 4'h6;
  localparam logic [3:0] AUDIO_CTL_IDX = 4'h0;
  // second page sits above the first
  localparam logic [7:0] PAGE2_BASE    = 8'h40;

  localparam logic [7:0] RSVD_A_ADDR    = {2'b00, RSVD_A_IDX, 2'b00};
  localparam logic [7:0] REF_CTL_ADDR   = {2'b00, REF_CTL_IDX, 2'b00};
  localparam logic [7:0] SOFT_RST_ADDR  = {2'b00, SOFT_RST_IDX, 2'b00};
  localparam logic [7:0] RSVD_B_ADDR    = {2'b00, RSVD_B_IDX, 2'b00};
  localparam logic [7:0] STATUS_ADDR    = {2'b00, STATUS_IDX, 2'b00};
  localparam logic [7:0] AUDIO_CTL_ADDR = PAGE2_BASE | {2'b00, AUDIO_CTL_IDX, 2'b00};

  // reset values
  localparam logic [15:0] RSVD_A_RST    = 16'hFFFF;
  localparam logic [15:0] RSVD_B_RST    = 16'h0000;
  localparam logic [15:0] SOFT_RST_RST  = 16'hFFFF;
  localparam logic [4:0]  REF_CTL_RST   = 5'h02;
  localparam logic [15:0] AUDIO_CTL_RST = 16'h0000;
  localparam logic [15:0] SOFT_RST_CODE = 16'hBB00;

  // reference control fields
  localparam int REF_SRC_BIT   = 4;
  localparam int SETTLE_LSB    = 2;
  localparam int SLEEP_BIT     = 1;
  localparam int REF_LEVEL_BIT = 0;

  // audio control fields
  localparam int HPF_LSB  = 14;
  localparam int MUX_LSB  = 12;
  localparam int SAMPLE_WORD_LENGTH_LSB = 10;
  localparam int FMT_LSB  = 8;
  localparam int DACR_LSB = 3;
  localparam int ADCR_LSB = 0;
  localparam logic [15:0] AUDIO_WMASK = 16'hFF3F;

  // status fields
  localparam int ST_PWR_BIT  = 0;
  localparam int ST_MEAS_BIT = 1;
  localparam int ST_FMT_BIT  = 2;

  localparam logic [1:0] FMT_RIGHT = 2'b10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // settling hold-off times
  localparam int CLK_MHZ       = 50;
  localparam int SETTLE_1_US   = 100;
  localparam int SETTLE_2_US   = 500;
  localparam int SETTLE_3_US   = 1000;
  localparam int SETTLE_1_CYC  = SETTLE_1_US * CLK_MHZ;
  localparam int SETTLE_2_CYC  = SETTLE_2_US * CLK_MHZ;
  localparam int SETTLE_3_CYC  = SETTLE_3_US * CLK_MHZ;
  localparam int SETTLE_W      = 16;

endpackage : crrac_pkg

// file: crrac_settle_timer.sv
// crrac_settle_timer: down counter that holds off measurements after
// the internal reference powers up.
// assumes start is a one-cycle pulse on the power-up edge.
`timescale 1ns/100ps
`default_nettype none
module crrac_settle_timer
  import crrac_pkg::*;
(
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  // control
  input  wire logic                start,
  input  wire logic                clear,
  input  wire logic [SETTLE_W-1:0] loadCount,
  // status
  output logic                     done
);

  logic [SETTLE_W-1:0] count_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n || clear) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= loadCount;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // the start cycle itself is never a settled cycle
  assign done = !start && (count_reg == '0);

  settle_load_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    start && !clear |=> count_reg == $past(loadCount))
    else $error("settle count not loaded");

  settle_hold_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (count_reg > 16'h0002) && !start && !clear |=> !done ##1 (!done || $past(clear)))
    else $error("settle hold-off ended early");

endmodule : crrac_settle_timer
`default_nettype wire

// file: crrac_regs.sv
// crrac_regs: AXI4-Lite register bank for measurement reference control,
// soft reset and the first audio control word, with decoded outputs.
// assumes convRequest is a level held by the converter while it wants
// the reference; all inputs are synchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module crrac_regs
  import crrac_pkg::*;
#(
  parameter int unsigned SETTLE_CYC_1 = SETTLE_1_CYC,
  parameter int unsigned SETTLE_CYC_2 = SETTLE_2_CYC,
  parameter int unsigned SETTLE_CYC_3 = SETTLE_3_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // measurement reference
  input  wire logic        convRequest,
  output logic             refSourceInternal,
  output logic             intRefPowerOn,
  output logic             intRefLevelHigh,
  output logic             measAllowed,
  // audio configuration
  output logic [1:0]       adcHighpassCorner,
  output logic             adcHighpassOn,
  output logic [1:0]       adcInputSelect,
  output logic             adcDifferential,
  output logic [5:0]       sampleWordBits,
  output logic [1:0]       serialFrameFormat,
  output logic             formatConflict,
  output logic [3:0]       dacDivX2,
  output logic [3:0]       adcDivX2
);

  // write channel holding
  logic        awHeld_reg;
  logic [7:0]  awAddr_reg;
  logic        wHeld_reg;
  logic [15:0] wData_reg;
  logic [1:0]  wStrb_reg;
  logic        bValid_reg;
  logic [1:0]  bResp_reg;
  // read channel
  logic        rValid_reg;
  logic [1:0]  rResp_reg;
  logic [15:0] rData_reg;
  logic [15:0] rData_next;
  logic        rHit_next;
  // registers
  logic [4:0]  refCtl_reg;
  logic [15:0] audio_reg;
  // write decode
  logic        doWrite;
  logic        wrRef;
  logic        wrAudio;
  logic        wrHit;
  logic        softReset;
  logic [15:0] laneMask;
  // reference power
  logic        sleepBetween;
  logic        settleNeeded;
  logic        powerPrev_reg;
  logic        settleStart;
  logic        settleDone;
  logic [SETTLE_W-1:0] settleLoad;
  logic [15:0] statusWord;

  // ---------------- write channel ----------------
  // address and data are taken in either order; one write at a time
  assign s_axi_awready = !awHeld_reg && !bValid_reg;
  assign s_axi_wready  = !wHeld_reg && !bValid_reg;
  assign doWrite       = awHeld_reg && wHeld_reg && !bValid_reg;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wHeld_reg <= 1'b0;
      wData_reg <= 16'h0000;
      wStrb_reg <= 2'b00;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= s_axi_wdata[15:0];
      wStrb_reg <= s_axi_wstrb[1:0];
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  assign wrRef   = doWrite && awAddr_reg[7:2] == REF_CTL_ADDR[7:2];
  assign wrAudio = doWrite && awAddr_reg[7:2] == AUDIO_CTL_ADDR[7:2];
  // the code only counts when both low byte lanes carry it
  assign softReset = doWrite && awAddr_reg[7:2] == SOFT_RST_ADDR[7:2]
                     && wStrb_reg == 2'b11
                     && wData_reg == SOFT_RST_CODE;
  assign laneMask  = {{8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

  always_comb begin
    unique case (awAddr_reg[7:2])
      RSVD_A_ADDR[7:2], REF_CTL_ADDR[7:2], SOFT_RST_ADDR[7:2],
      RSVD_B_ADDR[7:2], STATUS_ADDR[7:2], AUDIO_CTL_ADDR[7:2]: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bValid_reg <= 1'b0;
      bResp_reg  <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp  = bResp_reg;

  // ---------------- registers ----------------
  // reserved words, status and soft reset word are not stored at all,
  // so writes to them cannot change what is read back
  always_ff @(posedge mclk) begin
    if (!reset_n || softReset) begin
      refCtl_reg <= REF_CTL_RST;
    end else if (wrRef) begin
      refCtl_reg <= (wData_reg[4:0] & laneMask[4:0])
                    | (refCtl_reg & ~laneMask[4:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || softReset) begin
      audio_reg <= AUDIO_CTL_RST;
    end else if (wrAudio) begin
      // bits 7:6 stay zero
      audio_reg <= ((wData_reg & laneMask) | (audio_reg & ~laneMask))
                   & AUDIO_WMASK;
    end
  end

  // ---------------- reference control ----------------
  assign refSourceInternal = refCtl_reg[REF_SRC_BIT];
  assign intRefLevelHigh   = refCtl_reg[REF_LEVEL_BIT];
  assign sleepBetween      = refCtl_reg[SLEEP_BIT];
  // on demand in sleep mode, always on otherwise, never for external
  assign intRefPowerOn = refSourceInternal
                         && (!sleepBetween || convRequest);
  assign settleNeeded  = refSourceInternal && sleepBetween;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      powerPrev_reg <= 1'b0;
    end else begin
      powerPrev_reg <= intRefPowerOn;
    end
  end

  assign settleStart = intRefPowerOn && !powerPrev_reg && settleNeeded;

  always_comb begin
    unique case (refCtl_reg[SETTLE_LSB +: 2])
      2'b00: settleLoad = '0;
      2'b01: settleLoad = SETTLE_W'(SETTLE_CYC_1);
      2'b10: settleLoad = SETTLE_W'(SETTLE_CYC_2);
      2'b11: settleLoad = SETTLE_W'(SETTLE_CYC_3);
    endcase
  end

  crrac_settle_timer u_settle (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .start     (settleStart),
    .clear     (!intRefPowerOn),
    .loadCount (settleLoad),
    .done      (settleDone)
  );

  assign measAllowed = convRequest && (!settleNeeded || settleDone);

  // ---------------- audio decode ----------------
  assign adcHighpassCorner = audio_reg[HPF_LSB +: 2];
  assign adcHighpassOn     = audio_reg[HPF_LSB +: 2] != 2'b00;
  assign adcInputSelect    = audio_reg[MUX_LSB +: 2];
  assign adcDifferential   = audio_reg[MUX_LSB + 1];
  assign serialFrameFormat = audio_reg[FMT_LSB +: 2];

  always_comb begin
    unique case (audio_reg[SAMPLE_WORD_LENGTH_LSB +: 2])
      2'b00: sampleWordBits = 6'h10;
      2'b01: sampleWordBits = 6'h14;
      2'b10: sampleWordBits = 6'h18;
      2'b11: sampleWordBits = 6'h20;
    endcase
  end

  // divisors doubled so that 1.5 and 5.5 stay integral
  function automatic logic [3:0] divX2(input logic [2:0] code);
    unique case (code)
      3'd0: divX2 = 4'h2;
      3'd1: divX2 = 4'h3;
      3'd2: divX2 = 4'h4;
      3'd3: divX2 = 4'h6;
      3'd4: divX2 = 4'h8;
      3'd5: divX2 = 4'hA;
      3'd6: divX2 = 4'hB;
      3'd7: divX2 = 4'hC;
    endcase
  endfunction : divX2

  assign dacDivX2 = divX2(audio_reg[DACR_LSB +: 3]);
  assign adcDivX2 = divX2(audio_reg[ADCR_LSB +: 3]);

  // right justified is unusable when one rate is not a multiple of the other
  assign formatConflict = serialFrameFormat == FMT_RIGHT
                          && (dacDivX2 % adcDivX2 != 4'h0)
                          && (adcDivX2 % dacDivX2 != 4'h0);

  assign statusWord = {13'h0000, formatConflict, measAllowed, intRefPowerOn};

  // ---------------- read channel ----------------
  assign s_axi_arready = !rValid_reg;

  always_comb begin
    rHit_next  = 1'b1;
    rData_next = 16'h0000;
    unique case (s_axi_araddr[7:2])
      RSVD_A_ADDR[7:2]:    rData_next = RSVD_A_RST;
      REF_CTL_ADDR[7:2]:   rData_next = {11'h000, refCtl_reg};
      SOFT_RST_ADDR[7:2]:  rData_next = SOFT_RST_RST;
      RSVD_B_ADDR[7:2]:    rData_next = RSVD_B_RST;
      STATUS_ADDR[7:2]:    rData_next = statusWord;
      AUDIO_CTL_ADDR[7:2]: rData_next = audio_reg;
      default:             rHit_next  = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rValid_reg <= 1'b0;
      rResp_reg  <= RESP_OKAY;
      rData_reg  <= 16'h0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rValid_reg <= 1'b1;
      rResp_reg  <= rHit_next ? RESP_OKAY : RESP_SLVERR;
      rData_reg  <= rData_next;
    end else if (s_axi_rready) begin
      rValid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rresp  = rResp_reg;
  assign s_axi_rdata  = {16'h0000, rData_reg};

  // ---------------- checks ----------------
  ext_ref_off_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !refCtl_reg[REF_SRC_BIT] |-> !intRefPowerOn)
    else $error("internal reference on in external mode");

  ref_always_on_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    refCtl_reg[REF_SRC_BIT] && !refCtl_reg[SLEEP_BIT] |-> intRefPowerOn)
    else $error("internal reference not kept on");

  soft_reset_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    softReset |=> refCtl_reg == REF_CTL_RST && audio_reg == AUDIO_CTL_RST)
    else $error("soft reset did not restore defaults");

  rsvd_read_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == RSVD_A_ADDR[7:2]
    |=> s_axi_rvalid && s_axi_rdata[15:0] == RSVD_A_RST)
    else $error("reserved word read wrong value");

  settle_block_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    settleStart && refCtl_reg[SETTLE_LSB +: 2] != 2'b00 && convRequest
    |-> !measAllowed ##1 (!measAllowed || !convRequest || !settleNeeded))
    else $error("measurement allowed during settling");

  no_settle_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !settleNeeded && convRequest |-> measAllowed)
    else $error("measurement held without settling mode");

  word_len_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wrAudio && wStrb_reg[1] && !softReset && wData_reg[11:10] == 2'b10
    |=> sampleWordBits == 6'h18)
    else $error("word length not 24 after write");

  dac_rate_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wrAudio && wStrb_reg[0] && wData_reg[5:3] == 3'd6 |=> dacDivX2 == 4'hB)
    else $error("dac divider not 5.5");

  mux_diff_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    wrAudio && wStrb_reg[1] |=> adcDifferential == ($past(wData_reg[13:12]) >= 2'b10))
    else $error("differential input flag wrong");

  write_resp_a: assert property (
    @(posedge mclk) disable iff (!reset_n)
    doWrite |=> s_axi_bvalid && s_axi_bresp == (wrHit ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing");

endmodule : crrac_regs
`default_nettype wire

// file: crrac_host_model.sv
// crrac_host_model: AXI4-Lite host that programs the register bank.
// assumes one free-running mclk; one write and one read under way at most.
`timescale 1ns/100ps
`default_nettype none
module crrac_host_model (
  // clock
  input  wire logic        mclk,
  // write address
  output logic [7:0]       awAddr,
  output logic             awValid,
  input  wire logic        awReady,
  // write data
  output logic [31:0]      wData,
  output logic [3:0]       wStrb,
  output logic             wValid,
  input  wire logic        wReady,
  // write response
  input  wire logic [1:0]  bResp,
  input  wire logic        bValid,
  output logic             bReady,
  // read address
  output logic [7:0]       arAddr,
  output logic             arValid,
  input  wire logic        arReady,
  // read data
  input  wire logic [31:0] rData,
  input  wire logic [1:0]  rResp,
  input  wire logic        rValid,
  output logic             rReady,
  // count of transfers that never completed
  output logic [7:0]       hangCnt
);
  initial begin
    {awAddr, awValid, wData, wStrb, wValid, bReady} = '0;
    {arAddr, arValid, rReady, hangCnt} = '0;
  end

  // handshakes are judged at the falling edge, where the slave's ready is settled
  task automatic axiWrite(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                          output logic [1:0] resp);
    logic awDone, wDone, bDone;
    resp = 2'h3;
    @(posedge mclk);
    awAddr  <= a;
    wData   <= {16'h0000, d};
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge mclk);
      awDone = awValid && awReady;
      wDone  = wValid && wReady;
      bDone  = bValid;
      if (bDone) resp = bResp;
      @(posedge mclk);
      if (awDone) awValid <= 1'b0;
      if (wDone) wValid <= 1'b0;
      if (bDone) begin
        bReady <= 1'b0;
        return;
      end
    end
    // counted at once so the caller can stop the run in this step
    hangCnt = hangCnt + 8'h01;
  endtask : axiWrite

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic arDone, rDone;
    d = 32'hFFFFFFFF;
    resp = 2'h3;
    @(posedge mclk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge mclk);
      arDone = arValid && arReady;
      rDone  = rValid;
      if (rDone) begin
        d = rData;
        resp = rResp;
      end
      @(posedge mclk);
      if (arDone) arValid <= 1'b0;
      if (rDone) begin
        rReady <= 1'b0;
        return;
      end
    end
    hangCnt = hangCnt + 8'h01;
  endtask : axiRead
endmodule : crrac_host_model
`default_nettype wire

// file: codec_reference_reset_audio_config_tb_top.sv
// testbench for crrac_regs: register map, reference control and audio decode.
// assumes the host model above; settle counts shortened by parameter.
`timescale 1ns/100ps
`default_nettype none
module codec_reference_reset_audio_config_tb_top;
  import crrac_pkg::*;
  localparam int C1 = 5;
  localparam int C2 = 10;
  localparam int C3 = 20;
  localparam logic [5:0] WL [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  localparam logic [3:0] DV [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB, 4'hC};
  localparam int SE [4] = '{1, C1 + 1, C2 + 1, C3 + 1};
  logic mclk = 1'b0, reset_n = 1'b0, convRequest = 1'b0;
  logic [7:0] awAddr, arAddr, hangCnt;
  logic [31:0] wData, rData;
  logic [3:0] wStrb, dacDivX2, adcDivX2;
  logic [1:0] bResp, rResp, hpf, mux, fmt;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic refInt, refOn, refHigh, measAllowed, hpfOn, diff, conflict;
  logic [5:0] wordBits;
  logic [31:0] v;
  logic [1:0] r;
  int error_cnt = 0, comparisons = 0, k;

  always #10 mclk = ~mclk;

  crrac_host_model u_host (.mclk(mclk), .awAddr(awAddr), .awValid(awValid), .awReady(awReady),
    .wData(wData), .wStrb(wStrb), .wValid(wValid), .wReady(wReady), .bResp(bResp),
    .bValid(bValid), .bReady(bReady), .arAddr(arAddr), .arValid(arValid), .arReady(arReady),
    .rData(rData), .rResp(rResp), .rValid(rValid), .rReady(rReady), .hangCnt(hangCnt));

  crrac_regs #(.SETTLE_CYC_1(C1), .SETTLE_CYC_2(C2), .SETTLE_CYC_3(C3)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .convRequest(convRequest), .refSourceInternal(refInt), .intRefPowerOn(refOn),
    .intRefLevelHigh(refHigh), .measAllowed(measAllowed), .adcHighpassCorner(hpf),
    .adcHighpassOn(hpfOn), .adcInputSelect(mux), .adcDifferential(diff),
    .sampleWordBits(wordBits), .serialFrameFormat(fmt), .formatConflict(conflict),
    .dacDivX2(dacDivX2), .adcDivX2(adcDivX2));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : cmp

  // write with both low lanes, then let outputs settle before any check
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e = RESP_OKAY);
    u_host.axiWrite(a, d, 4'h3, r);
    if (hangCnt != 8'h00) conclude();
    cmp(r, e);
    @(negedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_host.axiRead(a, v, r);
    if (hangCnt != 8'h00) conclude();
    cmp(v, {16'h0000, e});
    cmp(r, RESP_OKAY);
  endtask : rd

  task automatic conclude();
    error_cnt += int'(hangCnt);
    $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rd(RSVD_A_ADDR, RSVD_A_RST);
    rd(REF_CTL_ADDR, 16'h0002);
    rd(SOFT_RST_ADDR, SOFT_RST_RST);
    rd(RSVD_B_ADDR, RSVD_B_RST);
    rd(AUDIO_CTL_ADDR, AUDIO_CTL_RST);
    wr(RSVD_A_ADDR, 16'h0000);
    wr(RSVD_B_ADDR, 16'hFFFF);
    wr(REF_CTL_ADDR, 16'hFFFF);
    wr(AUDIO_CTL_ADDR, 16'hFFFF);
    wr(8'h24, 16'h1234, RESP_SLVERR);
    rd(RSVD_A_ADDR, 16'hFFFF);
    rd(RSVD_B_ADDR, 16'h0000);
    rd(REF_CTL_ADDR, 16'h001F);
    rd(AUDIO_CTL_ADDR, 16'hFF3F);
    u_host.axiRead(8'h20, v, r);
    cmp(r, RESP_SLVERR);
    // external source with always-on asked: internal reference must stay off
    wr(REF_CTL_ADDR, 16'h0000);
    @(posedge mclk);
    convRequest <= 1'b1;
    @(negedge mclk);
    cmp(refInt, 1'b0);
    cmp(refOn, 1'b0);
    cmp(measAllowed, 1'b1);
    wr(REF_CTL_ADDR, 16'h001D);
    cmp({refInt, refOn, refHigh, measAllowed}, 4'hF);
    wr(REF_CTL_ADDR, 16'h001C);
    cmp(refHigh, 1'b0);
    @(posedge mclk);
    convRequest <= 1'b0;
    @(negedge mclk);
    cmp(refOn, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(REF_CTL_ADDR, 16'h0012 | 16'(c << 2));
      cmp(refOn, 1'b0);
      @(posedge mclk);
      convRequest <= 1'b1;
      k = 0;
      @(negedge mclk);
      while (measAllowed !== 1'b1 && k < 60) begin
        @(negedge mclk);
        k++;
      end
      cmp(k, SE[c]);
      cmp(refOn, 1'b1);
      @(posedge mclk);
      convRequest <= 1'b0;
      @(negedge mclk);
      cmp({refOn, measAllowed}, 2'b00);
    end
    for (int c = 0; c < 4; c++) begin
      wr(AUDIO_CTL_ADDR, 16'(c * 16'h5500));
      cmp({hpf, hpfOn}, {2'(c), c != 0});
      cmp({mux, diff}, {2'(c), c > 1});
      cmp(wordBits, WL[c]);
      cmp({fmt, conflict}, {2'(c), 1'b0});
    end
    for (int c = 0; c < 8; c++) begin
      // the reference rate is taken to sit in its legal band; only ratios are seen here
      wr(AUDIO_CTL_ADDR, 16'(c * 8 + 7 - c));
      cmp(dacDivX2, DV[c]);
      cmp(adcDivX2, DV[7 - c]);
    end
    wr(AUDIO_CTL_ADDR, 16'h0208);
    cmp({fmt, conflict}, 3'b101);
    // reference sleeping with no request, conflict flag up
    rd(STATUS_ADDR, 16'h0004);
    wr(AUDIO_CTL_ADDR, 16'h0212);
    cmp(conflict, 1'b0);
    // the code with one lane missing must not reset anything
    u_host.axiWrite(SOFT_RST_ADDR, SOFT_RST_CODE, 4'h1, r);
    rd(AUDIO_CTL_ADDR, 16'h0212);
    wr(SOFT_RST_ADDR, SOFT_RST_CODE);
    rd(REF_CTL_ADDR, 16'h0002);
    rd(AUDIO_CTL_ADDR, 16'h0000);
    rd(SOFT_RST_ADDR, 16'hFFFF);
    cmp({wordBits, dacDivX2, adcDivX2}, {6'h10, 4'h2, 4'h2});
    conclude();
  end
endmodule : codec_reference_reset_audio_config_tb_top
`default_nettype wire
